// >>> bench/scl_ee_model.sv
`timescale 1ns/100ps
module scl_ee_model (
  // Clock
  input wire logic clk_sys_i,
  // Engine side
  input wire scl_pkg::scl_ee_req_type req_i,
  output scl_pkg::scl_ee_rsp_type rsp_o,
  // Faults to inject
  input wire logic nack_i,
  input wire logic stall_i,
  input wire logic bad_sum_i,
  input wire logic err_i
);
  logic [15:0] mem [0:127];
  int wait_q = 0;
  int tbl_reads = 0;

  initial rsp_o = '0;

  always @(posedge clk_sys_i)
  begin
    rsp_o.done <= 1'b0;
    // Data only means something with done, so it churns otherwise
    rsp_o.rdata <= ~rsp_o.rdata;
    if (!req_i.req || rsp_o.done || stall_i)
      wait_q <= 0;
    else if (wait_q < 3)
      wait_q <= wait_q + 1;
    else
    begin
      rsp_o.done <= 1'b1;
      rsp_o.nack <= nack_i;
      rsp_o.err <= err_i;
      rsp_o.rdata <= mem[req_i.addr[6:0]]
        ^ {15'h0000, bad_sum_i && req_i.addr == 8'h3B};
      wait_q <= 0;
      if (req_i.addr >= 8'h08)
        tbl_reads <= tbl_reads + 1;
    end
  end
endmodule

// >>> bench/scl_loader_tb.sv
`timescale 1ns/100ps
module scl_loader_tb;
  localparam int BOOT = 20;
  localparam int RETRY = 40;
  localparam int RECOV = scl_pkg::SCL_HALF_CYC + BOOT;
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic host_cmd_valid_i = 1'b0;
  scl_pkg::scl_host_cmd_type host_cmd_i = '0;
  logic host_busy_o, host_rvalid_o, scl_o, scl_oe_o, temp_start_o;
  logic out_en_o, out_hiz_o;
  logic [15:0] host_rdata_o, out_code_o, gain_trim_o, offset_trim_o, alarm_o;
  logic [3:0][15:0] cfg_regs_o;
  scl_pkg::scl_ee_req_type ee_req_o;
  scl_pkg::scl_ee_rsp_type ee_rsp_i;
  logic sda_i = 1'b1;
  logic slave_active_i = 1'b0;
  logic three_wire_i = 1'b0;
  logic temp_done_i = 1'b0;
  logic [15:0] temp_code_i = 16'h0350;
  logic [3:0] sensor_fault_i = 4'h0;
  logic [4:0] front_fault_i = 5'h00;
  logic [15:0] sig_code_i = 16'h8000;
  logic nack = 1'b0, stall = 1'b0, bad_sum = 1'b0;
  logic err = 1'b0;
  // Word 3 lands in register 5: alarm high, limits on, all front enables
  logic [15:0] cfg [1:4] = '{16'h1111, 16'h2222, 16'hFEC2, 16'h4444};
  logic [15:0] rd;
  int err_total = 0, checks_done = 0, n;

  always #4 clk_sys_i = ~clk_sys_i;
  always #7.5 clk_link_i = ~clk_link_i;

  scl_loader #(.BOOT_CYC(BOOT), .RETRY_CYC(RETRY), .CONV_TMO_CYC(200),
    .ENTRY_BUDGET_CYC(60), .LOCK_TMO_CYC(30), .TW_EN_CYC(50)) dut (.*);

  scl_ee_model ee (.clk_sys_i(clk_sys_i), .req_i(ee_req_o),
    .rsp_o(ee_rsp_i), .nack_i(nack), .stall_i(stall), .bad_sum_i(bad_sum),
    .err_i(err));

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_req(output int cyc);
    for (cyc = 0; cyc < 5000 && ee_req_o.req !== 1'b1; cyc++)
      @(negedge clk_sys_i);
  endtask

  // Let the faulty word finish, clear faults, time the gap to next request
  task automatic fault_gap(output int cyc);
    for (cyc = 0; cyc < 20 && ee_req_o.req === 1'b1; cyc++)
      @(negedge clk_sys_i);
    {nack, err} = 2'b00;
    ee.mem[0] = 16'hA55A;
    wait_req(cyc);
  endtask

  task automatic run_pass();
    int t0, k;
    t0 = ee.tbl_reads;
    for (k = 0; k < 3000 && temp_start_o !== 1'b1; k++)
      @(negedge clk_sys_i);
    chk("temp_start", 16'h0001, {15'h0000, temp_start_o});
    repeat (10) @(negedge clk_sys_i);
    chk("req_in_conv", 16'h0000, {15'h0000, ee_req_o.req});
    temp_done_i = 1'b1;
    @(negedge clk_sys_i);
    temp_done_i = 1'b0;
    for (k = 0; k < 5000 && ee.tbl_reads < t0 + 52; k++)
      @(negedge clk_sys_i);
    repeat (3) @(negedge clk_sys_i);
  endtask

  // Reads only: config commits every pass would race a host write
  task automatic host(input logic [7:0] a, output logic [15:0] d);
    int k;
    @(negedge clk_link_i);
    host_cmd_i = '{1'b0, a, 16'h0000};
    host_cmd_valid_i = 1'b1;
    @(negedge clk_link_i);
    host_cmd_valid_i = 1'b0;
    chk("host_busy", 16'h0001, {15'h0000, host_busy_o});
    // EEPROM access waits for the sequencer, so allow a long answer
    for (k = 0; k < 400 && host_rvalid_o !== 1'b1; k++)
      @(negedge clk_link_i);
    d = host_rdata_o;
    chk("host_idle", 16'h0000, {15'h0000, host_busy_o});
  endtask

  initial
  begin
    #(50000 * 8);
    err_total++;
    give_verdict();
  end

  initial
  begin
    int s;
    for (int i = 0; i < 128; i++)
      ee.mem[i] = 16'h0000;
    ee.mem[0] = 16'hA55A;
    s = 0;
    for (int i = 1; i < 5; i++)
    begin
      ee.mem[i] = cfg[i];
      s += cfg[i];
    end
    ee.mem[5] = 16'(-s);
    s = 0;
    for (int i = 0; i < 17; i++)
    begin
      ee.mem[8 + 3 * i] = 16'(i << 8);
      ee.mem[9 + 3 * i] = 16'h1000 + 16'(i);
      ee.mem[10 + 3 * i] = 16'h2000 + 16'(i);
      s += (i << 8) + 16'h3000 + 2 * i;
    end
    ee.mem[59] = 16'(-s);
    repeat (6) @(negedge clk_sys_i);
    chk("en_rst", 16'h0000, {15'h0000, out_en_o});
    chk("gain_rst", 16'h0000, gain_trim_o);
    rst_n_i = 1'b1;
    wait_req(n);
    chk("boot_gap", 16'h0001, 16'(n >= BOOT && n <= BOOT + 5));
    chk("marker_addr", 16'h0000, {8'h00, ee_req_o.addr});
    run_pass();
    chk("tbl_reads", 16'h0034, 16'(ee.tbl_reads));
    chk("gain", 16'h1003, gain_trim_o);
    chk("offset", 16'h2003, offset_trim_o);
    chk("amp_en", 16'h0001, {15'h0000, out_en_o});
    for (int i = 0; i < 4; i++)
      chk("cfg_reg", cfg[i + 1], cfg_regs_o[i]);
    wait_req(n);
    chk("loop_addr", 16'h0000, {8'h00, ee_req_o.addr});
    // Amplifier stays on for the window, then frees the shared line
    three_wire_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    chk("tw_amp_on", 16'h0001, {15'h0000, out_en_o});
    repeat (20) @(negedge clk_sys_i);
    chk("tw_amp_off", 16'h0000, {15'h0000, out_en_o});
    three_wire_i = 1'b0;
    run_pass();
    chk("tbl_reads2", 16'h0068, 16'(ee.tbl_reads));
    chk("amp_again", 16'h0001, {15'h0000, out_en_o});
    sig_code_i = 16'hFFFF;
    repeat (3) @(negedge clk_sys_i);
    chk("clip_over", 16'hC000, out_code_o);
    sig_code_i = 16'h0000;
    repeat (3) @(negedge clk_sys_i);
    chk("clip_under", 16'h2FFF, out_code_o);
    sensor_fault_i = 4'h2;
    front_fault_i = 5'h1F;
    repeat (4) @(negedge clk_sys_i);
    chk("fault_rail", 16'hFFFF, out_code_o);
    chk("alarm", 16'h01F2, alarm_o);
    host(8'h08, rd);
    chk("host_alarm", 16'h01F2, rd);
    host(8'h02, rd);
    chk("host_gain", 16'h1003, rd);
    host(8'h07, rd);
    chk("host_unmapped", 16'h0000, rd);
    host(8'h85, rd);
    chk("host_ee", 16'h89C7, rd);
    sensor_fault_i = 4'h0;
    front_fault_i = 5'h00;
    bad_sum = 1'b1;
    run_pass();
    chk("hiz", 16'h0001, {15'h0000, out_hiz_o});
    chk("amp_off", 16'h0000, {15'h0000, out_en_o});
    bad_sum = 1'b0;
    nack = 1'b1;
    wait_req(n);
    fault_gap(n);
    chk("nack_gap", 16'h0001, 16'(n >= RETRY && n <= RETRY + 6));
    err = 1'b1;
    fault_gap(n);
    chk("err_gap", 16'h0001, 16'(n >= RECOV && n <= RECOV + 6));
    ee.mem[0] = 16'h0000;
    fault_gap(n);
    chk("marker_gap", 16'h0001, 16'(n >= RETRY && n <= RETRY + 6));
    stall = 1'b1;
    sda_i = 1'b0;
    slave_active_i = 1'b1;
    repeat (100) @(negedge clk_sys_i);
    chk("no_recov_slave", 16'h0000, {15'h0000, scl_oe_o});
    slave_active_i = 1'b0;
    for (n = 0; n < 300 && scl_oe_o !== 1'b1; n++)
      @(negedge clk_sys_i);
    chk("recov_pulse", 16'h0001, {15'h0000, scl_oe_o});
    chk("scl_low", 16'h0000, {15'h0000, scl_o});
    // Supply drop in mid-run must clear the latched bad-sum state
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk("hiz_rst", 16'h0000, {15'h0000, out_hiz_o});
    chk("oe_rst", 16'h0000, {15'h0000, scl_oe_o});
    give_verdict();
  end
endmodule

// >>> src/scl_loader.sv
`timescale 1ns/100ps
module scl_loader #(
  parameter int BOOT_CYC = scl_pkg::BOOT_WAIT_CYC,
  parameter int RETRY_CYC = scl_pkg::RETRY_WAIT_CYC,
  parameter int CONV_TMO_CYC = scl_pkg::CONV_CYC * scl_pkg::CONV_MARGIN,
  parameter int ENTRY_BUDGET_CYC = scl_pkg::ENTRY_CYC,
  parameter int LOCK_TMO_CYC = scl_pkg::LOCK_TMO_DEF,
  parameter int RECOV_PULSES = scl_pkg::RECOV_PULSE_DEF,
  parameter int TW_EN_CYC = scl_pkg::TW_EN_DEF,
  parameter int N_ENTRY = scl_pkg::TBL_ENTRIES,
  parameter logic [15:0] EE_MARKER = 16'hA55A
) (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_link_i,
  // Host link, clk_link_i domain
  input wire logic host_cmd_valid_i,
  input wire scl_pkg::scl_host_cmd_type host_cmd_i,
  output logic host_busy_o,
  output logic host_rvalid_o,
  output logic [15:0] host_rdata_o,
  // EEPROM transfer engine
  output scl_pkg::scl_ee_req_type ee_req_o,
  input wire scl_pkg::scl_ee_rsp_type ee_rsp_i,
  input wire logic slave_active_i,
  // Two-wire pins used for recovery
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  // Temperature converter
  output logic temp_start_o,
  input wire logic temp_done_i,
  input wire logic [15:0] temp_code_i,
  // Front end
  input wire logic [3:0] sensor_fault_i,
  input wire logic [4:0] front_fault_i,
  input wire logic three_wire_i,
  input wire logic [15:0] sig_code_i,
  // Conditioned output and trims
  output logic [15:0] out_code_o,
  output logic out_en_o,
  output logic out_hiz_o,
  output logic [15:0] gain_trim_o,
  output logic [15:0] offset_trim_o,
  output logic [15:0] alarm_o,
  output logic [3:0][15:0] cfg_regs_o
);

  localparam int CW = scl_pkg::CNT_W;
  localparam logic [CW-1:0] BOOT_L = CW'(BOOT_CYC - 1);
  localparam logic [CW-1:0] RETRY_L = CW'(RETRY_CYC - 1);
  localparam logic [CW-1:0] CONV_L = CW'(CONV_TMO_CYC - 1);
  localparam logic [CW-1:0] ENTRY_L = CW'(ENTRY_BUDGET_CYC - 1);
  localparam logic [CW-1:0] LOCK_L = CW'(LOCK_TMO_CYC - 1);
  localparam logic [CW-1:0] HALF_L = CW'(scl_pkg::SCL_HALF_CYC - 1);
  localparam logic [CW-1:0] TW_L = CW'(TW_EN_CYC - 1);
  localparam logic [7:0] PULSE_N = 8'(RECOV_PULSES);
  localparam logic [7:0] TBL_SUM_IDX = 8'(N_ENTRY * scl_pkg::ENTRY_WORDS);
  localparam logic [1:0] LAST_WSEL = 2'(scl_pkg::ENTRY_WORDS - 1);

  typedef struct packed {
    scl_pkg::scl_state_type st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] lk;
    logic [CW-1:0] tw;
    logic [7:0] idx;
    logic [1:0] wsel;
    logic hit;
    logic [15:0] sum;
    logic [3:0][15:0] shadow;
    logic [3:0][15:0] cfg;
    logic [15:0] temp;
    logic [15:0] gain;
    logic [15:0] zero;
    logic [15:0] cgain;
    logic [15:0] czero;
    scl_pkg::scl_ee_req_type ee;
    logic tstart;
    logic bad;
    logic amp;
    logic scl_oe;
    logic [7:0] pulses;
    logic [1:0] sda_s;
    logic [1:0] tw3_s;
    logic [1:0][3:0] sf_s;
    logic [1:0][4:0] ff_s;
    logic [2:0] req_s;
    logic ack_t;
    logic [15:0] rdata;
    logic hpend;
    logic [15:0] out;
    logic [15:0] alarm;
  } scl_sys_type;

  typedef struct packed {
    scl_pkg::scl_host_cmd_type cmd;
    logic req_t;
    logic [2:0] ack_s;
    logic busy;
    logic rvalid;
    logic [15:0] rdata;
  } scl_link_type;

  scl_sys_type s_q, s_d;
  scl_link_type l_q, l_d;
  logic [1:0] lrst_q;
  logic [15:0] sum_nx;
  logic rd_state;

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] r5);
    logic [15:0] over;
    logic [15:0] under;
    over = {r5[scl_pkg::R5_OVER_LSB +: 4], scl_pkg::OVER_FILL};
    under = {r5[scl_pkg::R5_UNDER_LSB +: 4], scl_pkg::UNDER_FILL};
    if (v > over)
      clip = over;
    else if (v < under)
      clip = under;
    else
      clip = v;
  endfunction

  function automatic logic [15:0] reg_read(input logic [6:0] a,
                                           input scl_sys_type s);
    logic [6:0] off;
    off = 7'(a - scl_pkg::REG_CFG_FIRST);
    if (a == scl_pkg::REG_TEMP)
      reg_read = s.temp;
    else if (a == scl_pkg::REG_ZERO)
      reg_read = s.zero;
    else if (a == scl_pkg::REG_GAIN)
      reg_read = s.gain;
    else if (a >= scl_pkg::REG_CFG_FIRST && a <= scl_pkg::REG_CFG_LAST)
      reg_read = s.cfg[off[1:0]];
    else if (a == scl_pkg::REG_ALARM)
      reg_read = s.alarm;
    else
      reg_read = '0;
  endfunction

  assign sum_nx = 16'(s_q.sum + ee_rsp_i.rdata);
  assign rd_state = s_q.st == scl_pkg::S_MARK || s_q.st == scl_pkg::S_CFG
                    || s_q.st == scl_pkg::S_TBL;

  // Link domain: host word capture; byte framing sits in the link PHY
  always_ff @(posedge clk_link_i)
  begin
    lrst_q <= {lrst_q[0], rst_n_i};
  end

  always_comb
  begin
    l_d = l_q;
    l_d.rvalid = 1'b0;
    l_d.ack_s = {l_q.ack_s[1:0], s_q.ack_t};
    // Commands while busy are dropped; host must watch busy
    if (host_cmd_valid_i && !l_q.busy)
    begin
      l_d.cmd = host_cmd_i;
      l_d.req_t = ~l_q.req_t;
      l_d.busy = 1'b1;
    end
    if (l_q.ack_s[2] != l_q.ack_s[1])
    begin
      l_d.busy = 1'b0;
      l_d.rvalid = 1'b1;
      l_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge clk_link_i)
  begin
    if (!lrst_q[1])
      l_q <= '0;
    else
      l_q <= l_d;
  end

  // System domain sequencer
  always_comb
  begin
    s_d = s_q;
    s_d.tstart = 1'b0;
    s_d.sda_s = {s_q.sda_s[0], sda_i};
    s_d.tw3_s = {s_q.tw3_s[0], three_wire_i};
    s_d.sf_s = {s_q.sf_s[0], sensor_fault_i};
    s_d.ff_s = {s_q.ff_s[0], front_fault_i};
    s_d.req_s = {s_q.req_s[1:0], l_q.req_t};

    // Host access; cmd fields stay still while the toggle is open
    if (s_q.req_s[2] != s_q.req_s[1])
    begin
      if (l_q.cmd.addr[scl_pkg::HOST_EE_SEL])
        s_d.hpend = 1'b1;
      else
      begin
        if (l_q.cmd.we && l_q.cmd.addr[6:0] >= scl_pkg::REG_CFG_FIRST
            && l_q.cmd.addr[6:0] <= scl_pkg::REG_CFG_LAST)
          s_d.cfg[2'(l_q.cmd.addr[6:0] - scl_pkg::REG_CFG_FIRST)] =
            l_q.cmd.wdata;
        s_d.rdata = reg_read(l_q.cmd.addr[6:0], s_q);
        s_d.ack_t = ~s_q.ack_t;
      end
    end

    // Lockup guard runs only while this master tries to start
    if (rd_state && s_q.ee.req && !slave_active_i && !s_q.sda_s[1])
      s_d.lk = s_q.lk + 1'b1;
    else
      s_d.lk = '0;

    case (s_q.st)
      scl_pkg::S_BOOT:
      begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == BOOT_L)
        begin
          s_d.cnt = '0;
          s_d.st = scl_pkg::S_MARK;
        end
      end
      scl_pkg::S_MARK, scl_pkg::S_CFG, scl_pkg::S_TBL:
      begin
        if (s_q.st == scl_pkg::S_TBL)
          s_d.cnt = s_q.cnt - 1'b1;
        if (!s_q.ee.req && !ee_rsp_i.done)
        begin
          s_d.ee.req = 1'b1;
          s_d.ee.we = 1'b0;
          if (s_q.st == scl_pkg::S_MARK)
            s_d.ee.addr = scl_pkg::EE_MARK_ADDR;
          else if (s_q.st == scl_pkg::S_CFG)
            s_d.ee.addr = s_q.idx;
          else
            s_d.ee.addr = 8'(scl_pkg::EE_TBL_BASE + s_q.idx);
        end
        if (s_q.ee.req && ee_rsp_i.done)
        begin
          s_d.ee.req = 1'b0;
          if (ee_rsp_i.nack)
          begin
            s_d.cnt = RETRY_L;
            s_d.st = scl_pkg::S_WAIT;
          end
          else if (ee_rsp_i.err)
          begin
            s_d.cnt = HALF_L;
            s_d.st = scl_pkg::S_RECOV;
          end
          else if (s_q.st == scl_pkg::S_MARK)
          begin
            s_d.sum = '0;
            s_d.idx = scl_pkg::EE_CFG_FIRST;
            s_d.st = scl_pkg::S_CFG;
            if (ee_rsp_i.rdata != EE_MARKER)
            begin
              s_d.cnt = RETRY_L;
              s_d.st = scl_pkg::S_WAIT;
            end
          end
          else if (s_q.st == scl_pkg::S_CFG)
          begin
            s_d.sum = sum_nx;
            s_d.idx = s_q.idx + 1'b1;
            if (s_q.idx != scl_pkg::EE_SUM1_ADDR)
              s_d.shadow[2'(s_q.idx - scl_pkg::EE_CFG_FIRST)] =
                ee_rsp_i.rdata;
            else if (sum_nx == '0)
            begin
              s_d.cfg = s_q.shadow;
              s_d.st = scl_pkg::S_TSTART;
            end
            else
            begin
              s_d.bad = 1'b1;
              s_d.amp = 1'b0;
              s_d.cnt = RETRY_L;
              s_d.st = scl_pkg::S_WAIT;
            end
          end
          else
          begin
            s_d.sum = sum_nx;
            s_d.idx = s_q.idx + 1'b1;
            if (s_q.idx == TBL_SUM_IDX)
            begin
              s_d.st = scl_pkg::S_UPD;
              if (sum_nx != '0)
              begin
                s_d.bad = 1'b1;
                s_d.amp = 1'b0;
                s_d.cnt = RETRY_L;
                s_d.st = scl_pkg::S_WAIT;
              end
            end
            else if (s_q.wsel == '0)
            begin
              s_d.hit = ee_rsp_i.rdata <= s_q.temp || s_q.idx == '0;
              s_d.wsel = s_q.wsel + 1'b1;
            end
            else
            begin
              if (s_q.hit && s_q.wsel == LAST_WSEL)
                s_d.czero = ee_rsp_i.rdata;
              else if (s_q.hit)
                s_d.cgain = ee_rsp_i.rdata;
              s_d.wsel = s_q.wsel + 1'b1;
              if (s_q.wsel == LAST_WSEL)
              begin
                s_d.wsel = '0;
                s_d.cnt = ENTRY_L;
              end
            end
          end
        end
        else if ((s_q.st == scl_pkg::S_TBL && s_q.cnt == '0)
                 || s_q.lk == LOCK_L)
        begin
          s_d.ee.req = 1'b0;
          s_d.cnt = HALF_L;
          s_d.st = scl_pkg::S_RECOV;
        end
      end
      scl_pkg::S_TSTART:
      begin
        s_d.tstart = 1'b1;
        s_d.cnt = CONV_L;
        s_d.st = scl_pkg::S_TWAIT;
      end
      scl_pkg::S_TWAIT:
      begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (temp_done_i)
        begin
          s_d.temp = temp_code_i;
          s_d.idx = '0;
          s_d.wsel = '0;
          s_d.sum = '0;
          s_d.cnt = ENTRY_L;
          s_d.st = scl_pkg::S_TBL;
        end
        else if (s_q.cnt == '0)
        begin
          s_d.cnt = RETRY_L;
          s_d.st = scl_pkg::S_WAIT;
        end
      end
      scl_pkg::S_UPD:
      begin
        s_d.gain = s_q.cgain;
        s_d.zero = s_q.czero;
        s_d.amp = 1'b1;
        s_d.bad = 1'b0;
        s_d.tw = TW_L;
        s_d.st = s_q.hpend ? scl_pkg::S_HOST : scl_pkg::S_MARK;
      end
      scl_pkg::S_WAIT:
      begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == '0)
          s_d.st = s_q.hpend ? scl_pkg::S_HOST : scl_pkg::S_MARK;
      end
      scl_pkg::S_RECOV:
      begin
        // Pulse rate stays at or below the fastest bus clock
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == '0)
        begin
          s_d.cnt = HALF_L;
          s_d.scl_oe = ~s_q.scl_oe;
          if (s_q.scl_oe)
            s_d.pulses = s_q.pulses + 1'b1;
          if (!s_q.scl_oe && (s_q.sda_s[1] || s_q.pulses == PULSE_N))
          begin
            s_d.scl_oe = 1'b0;
            s_d.pulses = '0;
            s_d.cnt = BOOT_L;
            s_d.st = scl_pkg::S_WAIT;
          end
        end
      end
      scl_pkg::S_HOST:
      begin
        if (!s_q.ee.req && !ee_rsp_i.done)
        begin
          s_d.ee.req = 1'b1;
          s_d.ee.we = l_q.cmd.we;
          s_d.ee.addr = {1'b0, l_q.cmd.addr[6:0]};
          s_d.ee.wdata = l_q.cmd.wdata;
        end
        if (s_q.ee.req && ee_rsp_i.done)
        begin
          s_d.ee.req = 1'b0;
          s_d.rdata = (ee_rsp_i.nack || ee_rsp_i.err) ? '0
                      : ee_rsp_i.rdata;
          s_d.ack_t = ~s_q.ack_t;
          s_d.hpend = 1'b0;
          s_d.st = scl_pkg::S_MARK;
        end
      end
      default:
        s_d.st = scl_pkg::S_BOOT;
    endcase

    // Three-wire sharing: release the line after the interval
    if (s_q.tw3_s[1] && s_q.amp && s_q.st != scl_pkg::S_UPD)
    begin
      s_d.tw = s_q.tw - 1'b1;
      if (s_q.tw == '0)
        s_d.amp = 1'b0;
    end

    s_d.alarm = '0;
    s_d.alarm[3:0] = s_q.sf_s[1];
    s_d.alarm[scl_pkg::ALM_FRONT_LSB +: 5] = s_q.ff_s[1]
      & s_q.cfg[scl_pkg::CFG_SLOT_R5][scl_pkg::R5_FRONT_EN_LSB +: 5];
    if (|s_q.sf_s[1])
      s_d.out = s_q.cfg[scl_pkg::CFG_SLOT_R5][scl_pkg::R5_ALARM_HIGH]
                ? scl_pkg::RAIL_HIGH : scl_pkg::RAIL_LOW;
    else if (s_q.cfg[scl_pkg::CFG_SLOT_R5][scl_pkg::R5_LIMIT_EN])
      s_d.out = clip(sig_code_i, s_q.cfg[scl_pkg::CFG_SLOT_R5]);
    else
      s_d.out = sig_code_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign host_busy_o = l_q.busy;
  assign host_rvalid_o = l_q.rvalid;
  assign host_rdata_o = l_q.rdata;
  assign ee_req_o = s_q.ee;
  assign scl_o = 1'b0;
  assign scl_oe_o = s_q.scl_oe;
  assign temp_start_o = s_q.tstart;
  assign out_code_o = s_q.out;
  assign out_en_o = s_q.amp;
  assign out_hiz_o = s_q.bad;
  assign gain_trim_o = s_q.gain;
  assign offset_trim_o = s_q.zero;
  assign alarm_o = s_q.alarm;
  assign cfg_regs_o = s_q.cfg;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking

  a_reset_init: assert property (
    !rst_n_i |=> s_q.st == scl_pkg::S_BOOT && !ee_req_o.req && !out_hiz_o)
    else $error("reset did not clear sequencer");
  a_boot_quiet: assert property (disable iff (!rst_n_i)
    s_q.st == scl_pkg::S_BOOT |-> !ee_req_o.req && s_q.cnt <= BOOT_L)
    else $error("EEPROM touched during boot wait");
  a_marker_retry: assert property (disable iff (!rst_n_i)
    s_q.st == scl_pkg::S_MARK && ee_req_o.req && ee_rsp_i.done
    && !ee_rsp_i.nack && !ee_rsp_i.err && ee_rsp_i.rdata != EE_MARKER
    |=> s_q.st == scl_pkg::S_WAIT && s_q.cnt == RETRY_L)
    else $error("bad marker not retried after long wait");
  a_nack_retry: assert property (disable iff (!rst_n_i)
    rd_state && ee_req_o.req && ee_rsp_i.done && ee_rsp_i.nack
    |=> s_q.st == scl_pkg::S_WAIT && s_q.cnt == RETRY_L)
    else $error("missing answer not retried after long wait");
  a_err_recover: assert property (disable iff (!rst_n_i)
    rd_state && ee_req_o.req && ee_rsp_i.done && ee_rsp_i.err
    && !ee_rsp_i.nack |=> s_q.st == scl_pkg::S_RECOV ##1 scl_oe_o == 1'b0)
    else $error("read error did not start bus recovery");
  a_conv_pulse: assert property (disable iff (!rst_n_i)
    temp_start_o |-> $past(s_q.st) == scl_pkg::S_TSTART ##1 !temp_start_o)
    else $error("conversion start not a single pulse after config");
  a_trim_gate: assert property (disable iff (!rst_n_i)
    $changed(gain_trim_o) || $rose(out_en_o)
    |-> $past(s_q.st) == scl_pkg::S_UPD)
    else $error("trims or amplifier changed outside update");
  a_fault_rail: assert property (disable iff (!rst_n_i)
    |s_q.sf_s[1] ##1 |s_q.sf_s[1]
    |-> out_code_o == scl_pkg::RAIL_HIGH || out_code_o == scl_pkg::RAIL_LOW)
    else $error("sensor fault did not drive output to a rail");
  a_hiz_bad_sum: assert property (disable iff (!rst_n_i)
    s_q.st == scl_pkg::S_TBL && ee_req_o.req && ee_rsp_i.done
    && !ee_rsp_i.nack && !ee_rsp_i.err && s_q.idx == TBL_SUM_IDX
    && sum_nx != '0 |=> out_hiz_o && !out_en_o)
    else $error("bad table sum left output driven");
  a_lock_slave: assert property (disable iff (!rst_n_i)
    slave_active_i |=> s_q.lk == '0)
    else $error("lockup timer ran during slave traffic");

  c_full_pass: cover property (disable iff (!rst_n_i)
    s_q.st == scl_pkg::S_UPD);
  c_recovery: cover property (disable iff (!rst_n_i)
    s_q.st == scl_pkg::S_RECOV ##1 scl_oe_o);
  c_host_ee: cover property (disable iff (!rst_n_i)
    s_q.st == scl_pkg::S_HOST && ee_rsp_i.done);

endmodule

// >>> src/scl_pkg.sv
package scl_pkg;

  // Timing base
  localparam int CLK_MHZ = 125;
  localparam int BOOT_WAIT_US = 25000;
  localparam int BOOT_WAIT_CYC = BOOT_WAIT_US * CLK_MHZ;
  localparam int RETRY_WAIT_US = 1000000;
  localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * CLK_MHZ;
  localparam int CONV_TIME_US = 125000;
  localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
  localparam int CONV_MARGIN = 2;
  localparam int ENTRY_TIME_US = 500;
  localparam int ENTRY_CYC = ENTRY_TIME_US * CLK_MHZ;
  // Fastest two-wire clock, half period rounded up
  localparam int SCL_HALF_NS = 1250;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int SCL_MIN_HZ = 1000;
  localparam int LINK_MIN_BPS = 4800;
  localparam int LINK_MAX_BPS = 38400;
  localparam int CNT_W = 27;
  // Lockup timeout, recovery pulse count and three-wire window
  localparam int LOCK_TMO_US = 1000;
  localparam int LOCK_TMO_DEF = LOCK_TMO_US * CLK_MHZ;
  localparam int RECOV_PULSE_DEF = 9;
  localparam int TW_EN_US = 10000;
  localparam int TW_EN_DEF = TW_EN_US * CLK_MHZ;

  // EEPROM word layout
  localparam logic [7:0] EE_MARK_ADDR = 8'h00;
  localparam logic [7:0] EE_CFG_FIRST = 8'h01;
  localparam logic [7:0] EE_SUM1_ADDR = 8'h05;
  localparam logic [7:0] EE_TBL_BASE = 8'h08;
  localparam int TBL_ENTRIES = 17;
  localparam int ENTRY_WORDS = 3;

  // Internal register indexes
  localparam logic [6:0] REG_TEMP = 7'h00;
  localparam logic [6:0] REG_ZERO = 7'h01;
  localparam logic [6:0] REG_GAIN = 7'h02;
  localparam logic [6:0] REG_CFG_FIRST = 7'h03;
  localparam logic [6:0] REG_CFG_LAST = 7'h06;
  localparam logic [6:0] REG_ALARM = 7'h08;
  localparam int HOST_EE_SEL = 7;

  // Slot of register 5 in the config array and its fields
  localparam logic [1:0] CFG_SLOT_R5 = 2'h2;
  localparam int R5_ALARM_HIGH = 15;
  localparam int R5_LIMIT_EN = 14;
  localparam int R5_FRONT_EN_LSB = 9;
  localparam int R5_OVER_LSB = 4;
  localparam int R5_UNDER_LSB = 0;
  localparam int ALM_FRONT_LSB = 4;
  localparam logic [11:0] OVER_FILL = 12'h000;
  localparam logic [11:0] UNDER_FILL = 12'hFFF;
  localparam logic [15:0] RAIL_HIGH = 16'hFFFF;
  localparam logic [15:0] RAIL_LOW = 16'h0000;

  typedef enum logic [3:0] {
    S_BOOT = 4'h0, S_MARK = 4'h1, S_CFG = 4'h3, S_TSTART = 4'h2,
    S_TWAIT = 4'h6, S_TBL = 4'h7, S_UPD = 4'h5, S_WAIT = 4'h4,
    S_RECOV = 4'hC, S_HOST = 4'hD
  } scl_state_type;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } scl_host_cmd_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } scl_ee_req_type;

  typedef struct packed {
    logic done;
    logic nack;
    logic err;
    logic [15:0] rdata;
  } scl_ee_rsp_type;

endpackage
